// >>> shared/srmc_pkg.sv
//=============================================================
// srmc_pkg
//=============================================================
// Purpose: constants and types for the supply regulator monitor
// Assumes: single 50 MHz clock domain
// Notes:   field widths and reset codes are plain defaults
package srmc_pkg;
   localparam int          SEL_W      = 2;
   localparam int          TRIM_W     = 8;
   localparam int          RATE_W     = 3;
   localparam int          SYNC_W     = 6;
   // default output level code, meaning the 1.8V output
   localparam logic [1:0]  SEL_1V8    = 2'h0;
   localparam logic [7:0]  TRIM_RST   = 8'h80;
   // monitor control encodings
   localparam logic [1:0]  CTRL_OFF   = 2'h0;
   localparam logic [1:0]  CTRL_RESET = 2'h1;
   localparam logic [1:0]  CTRL_FLAG  = 2'h2;
   localparam logic [2:0]  RATE_RST   = 3'h0;
   // sampling timing in low-frequency rc ticks
   localparam logic [15:0] SAMP_BASE  = 16'h0010;
   localparam logic [15:0] MEAS_TICKS = 16'h0002;
   // bit positions inside the request synchroniser vector
   localparam int          S_REG      = 0;
   localparam int          S_HS_EN    = 1;
   localparam int          S_HS_MASK  = 2;
   localparam int          S_CORE_EN  = 3;
   localparam int          S_CORE_MSK = 4;
   localparam int          S_SM_ON    = 5;
   localparam logic [5:0]  SYNC_RST   = 6'h0b;

   typedef enum logic [1:0] {
      CAL_LOAD = 2'b01,
      CAL_DONE = 2'b10
   } srmc_cal_t;
endpackage : srmc_pkg

// >>> src/srmc_sync.sv
//=============================================================
// srmc_sync
//=============================================================
// Purpose: two-flop synchroniser bank for request bits
// Assumes: synchronous active-low reset
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module srmc_sync
   import srmc_pkg::*;
#(
   parameter int         W    = SYNC_W,
   parameter logic [5:0] INIT = SYNC_RST
) (
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;

   // one pair of flops per bit
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
         if (!rstn) begin
            meta_q[i] <= INIT[i];
            q[i]      <= INIT[i];
         end else begin
            meta_q[i] <= d[i];
            q[i]      <= meta_q[i];
         end
      end
   end
endmodule : srmc_sync

// >>> src/srmc_sampler.sv
//=============================================================
// srmc_sampler
//=============================================================
// Purpose: sampling-mode timer for the supply monitor
// Assumes: rc_tick is a one-cycle pulse per low-freq rc period
// Notes:   period is SAMP_BASE shifted left by the rate field
`timescale 1ns/1ps
module srmc_sampler
   import srmc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              run,
   input  wire logic              rc_tick,
   input  wire logic [RATE_W-1:0] rate,
   output logic                   meas_on,
   output logic                   meas_done
);
   logic [15:0] cnt_q;
   logic [15:0] period;

   assign period = 16'(SAMP_BASE << rate);

   // tick counter, restarts each period; idles when not sampling
   always_ff @(posedge clk) begin
      if (!rstn || !run) begin
         cnt_q <= 16'h0000;
      end else if (rc_tick) begin
         cnt_q <= (cnt_q >= period - 16'h0001) ? 16'h0000
                                               : cnt_q + 16'h0001;
      end
   end

   // short measure window at the start of each period
   always_ff @(posedge clk) begin
      if (!rstn) begin
         meas_on   <= 1'b0;
         meas_done <= 1'b0;
      end else begin
         meas_on   <= run && (cnt_q < MEAS_TICKS);
         meas_done <= run && rc_tick && (cnt_q == MEAS_TICKS - 16'h0001);
      end
   end
endmodule : srmc_sampler

// >>> src/srmc_ctrl.sv
//=============================================================
// srmc_ctrl
//=============================================================
// Purpose: regulator, detector and supply monitor control
// Assumes: por_rst is high together with rstn low on power-on
// Notes:   software fields are plain ports with write strobes
//
// Function
// - regulator control writes take effect only while unlocked
// - freeze bit locks regulator control until power-on reset
// - regulator enable sets at por and wake; on bit shows real state
// - output level select resets to the 1.8V code
// - regulator ok status reads one once output reaches threshold
// - trim loads fuse value after por; software may override
// - calibration redone after any reset if done bit clear
// - high-supply detector on by default; status shows real state
// - high-supply mask ignores its reset once synchronised
// - value bit shows unmasked high-supply detector output
// - core detector on by default; status shows real state
// - while debugging, writing zero to core detector enable ignored
// - core mask ignores core detector reset once synchronised
// - value bit shows unmasked core detector output
// - monitor register needs unlock; freeze holds until reset
// - monitor resets off; enabling it disables high-supply detector
// - sampling in deep and static sleep or when forced
// - sampling runs on rc ticks, requests rc, at selected rate
// - detect flag follows supply below threshold while enabled
// - interrupt on flag rising edge when mask bit set
// - control one makes reset on low supply; two only flags
`timescale 1ns/1ps
module srmc_ctrl
   import srmc_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              por_rst,
   input  wire logic              wake_shutdown,
   input  wire logic              debug_active,
   input  wire logic              deep_sleep_mode,
   input  wire logic              static_sleep_mode,
   input  wire logic              rc_tick,
   input  wire logic              fuse_valid,
   input  wire logic [TRIM_W-1:0] fuse_trim,
   input  wire logic              unlock,
   input  wire logic              vreg_wr,
   input  wire logic              w_reg_en,
   input  wire logic [SEL_W-1:0]  w_level,
   input  wire logic [TRIM_W-1:0] w_trim,
   input  wire logic              w_fcd,
   input  wire logic              w_hs_en,
   input  wire logic              w_hs_mask,
   input  wire logic              w_core_en,
   input  wire logic              w_core_mask,
   input  wire logic              w_vreg_freeze,
   input  wire logic              sm_wr,
   input  wire logic [1:0]        w_sm_ctrl,
   input  wire logic              w_force_sampling,
   input  wire logic [RATE_W-1:0] w_rate,
   input  wire logic              w_sm_freeze,
   input  wire logic              int_enable_set,
   input  wire logic              int_disable_set,
   input  wire logic              reg_ok_in,
   input  wire logic              hs_det_in,
   input  wire logic              core_det_in,
   input  wire logic              sm_below_in,
   output logic                   reg_en,
   output logic [SEL_W-1:0]       output_level_select,
   output logic [TRIM_W-1:0]      trim_value,
   output logic                   fuse_calibration_done,
   output logic                   cpu_run_ok,
   output logic                   vreg_frozen,
   output logic                   reg_on,
   output logic                   regulator_output_ok,
   output logic                   high_supply_detector_state,
   output logic                   high_supply_reset_mask,
   output logic                   high_supply_detector_output,
   output logic                   core_detector_state,
   output logic                   core_reset_mask,
   output logic                   core_detector_output,
   output logic [1:0]             sm_ctrl,
   output logic                   force_sampling,
   output logic [RATE_W-1:0]      sampling_rate_select,
   output logic                   sm_frozen,
   output logic                   monitor_on_indicator,
   output logic                   sm_sampling,
   output logic                   sm_measure_en,
   output logic                   rc_osc_request,
   output logic                   supply_detect_flag,
   output logic                   interrupt_mask,
   output logic                   irq,
   output logic                   por_request
);
   //==========================================================
   // write qualification
   //==========================================================
   logic      vreg_we;
   logic      sm_we;
   srmc_cal_t cal_q;
   logic      hs_mask_q;
   logic      core_mask_q;

   // locked or frozen writes are dropped silently
   assign vreg_we = vreg_wr && unlock && !vreg_frozen
                    && (cal_q == CAL_DONE);
   assign sm_we   = sm_wr && unlock && !sm_frozen;

   //==========================================================
   // regulator control fields, held across non-por resets
   //==========================================================
   always_ff @(posedge clk) begin
      if (!rstn) begin
         if (por_rst) begin
            reg_en              <= 1'b1;
            output_level_select <= SEL_1V8;
            hs_mask_q           <= 1'b0;
            core_mask_q         <= 1'b0;
            vreg_frozen         <= 1'b0;
         end
      end else begin
         if (vreg_we) begin
            reg_en                 <= w_reg_en;
            output_level_select    <= w_level;
            hs_mask_q              <= w_hs_mask;
            core_mask_q            <= w_core_mask;
            vreg_frozen            <= w_vreg_freeze;
         end
         // wake from shutdown always restarts the regulator
         if (wake_shutdown) begin
            reg_en <= 1'b1;
         end
      end
   end

   // detector enables; debug keeps the core detector alive
   logic hs_en_q;
   logic core_en_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         if (por_rst) begin
            hs_en_q   <= 1'b1;
            core_en_q <= 1'b1;
         end
      end else if (vreg_we) begin
         hs_en_q <= w_hs_en;
         if (w_core_en || !debug_active) begin
            core_en_q <= w_core_en;
         end
      end
   end

   //==========================================================
   // fuse calibration sequence
   //==========================================================
   // cpu is held until trim is loaded; software override after
   always_ff @(posedge clk) begin
      if (!rstn) begin
         if (por_rst) begin
            fuse_calibration_done <= 1'b0;
            trim_value            <= TRIM_RST;
         end
         cal_q <= (por_rst || !fuse_calibration_done)
                  ? CAL_LOAD : CAL_DONE;
      end else begin
         case (cal_q)
            CAL_LOAD: begin
               if (fuse_valid) begin
                  trim_value            <= fuse_trim;
                  fuse_calibration_done <= 1'b1;
                  cal_q                 <= CAL_DONE;
               end
            end
            CAL_DONE: begin
               if (vreg_we) begin
                  trim_value            <= w_trim;
                  fuse_calibration_done <= w_fcd;
               end
            end
            default: cal_q <= CAL_LOAD;
         endcase
      end
   end

   assign cpu_run_ok = (cal_q == CAL_DONE);

   //==========================================================
   // supply monitor register and interrupt mask
   //==========================================================
   // cleared by any reset, unlike the regulator fields
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sm_ctrl              <= CTRL_OFF;
         force_sampling       <= 1'b0;
         sampling_rate_select <= RATE_RST;
         sm_frozen            <= 1'b0;
      end else if (sm_we) begin
         sm_ctrl              <= w_sm_ctrl;
         force_sampling       <= w_force_sampling;
         sampling_rate_select <= w_rate;
         sm_frozen            <= w_sm_freeze;
      end
   end

   // enable set wins over a disable in the same cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         interrupt_mask <= 1'b0;
      end else if (int_enable_set) begin
         interrupt_mask <= 1'b1;
      end else if (int_disable_set) begin
         interrupt_mask <= 1'b0;
      end
   end

   //==========================================================
   // request synchronisers toward the analog side
   //==========================================================
   logic [SYNC_W-1:0] req;
   logic [SYNC_W-1:0] req_s;

   // the monitor overrides the high-supply detector enable
   always_comb begin
      req             = '0;
      req[S_REG]      = reg_en;
      req[S_HS_EN]    = hs_en_q && (sm_ctrl == CTRL_OFF);
      req[S_HS_MASK]  = hs_mask_q;
      req[S_CORE_EN]  = core_en_q;
      req[S_CORE_MSK] = core_mask_q;
      req[S_SM_ON]    = (sm_ctrl != CTRL_OFF);
   end

   srmc_sync #(
      .W    (SYNC_W),
      .INIT (SYNC_RST)
   ) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    (req),
      .q    (req_s)
   );

   // status shows the synchronised, effective state
   assign reg_on                     = req_s[S_REG];
   assign high_supply_detector_state = req_s[S_HS_EN];
   assign core_detector_state        = req_s[S_CORE_EN];
   assign monitor_on_indicator       = req_s[S_SM_ON];
   // mask read-back shows one only once the mask has taken effect
   assign high_supply_reset_mask     = req_s[S_HS_MASK];
   assign core_reset_mask            = req_s[S_CORE_MSK];

   // raw detector and regulator levels, unmasked
   always_ff @(posedge clk) begin
      if (!rstn) begin
         regulator_output_ok         <= 1'b0;
         high_supply_detector_output <= 1'b0;
         core_detector_output        <= 1'b0;
      end else begin
         regulator_output_ok         <= reg_ok_in;
         high_supply_detector_output <= hs_det_in;
         core_detector_output        <= core_det_in;
      end
   end

   //==========================================================
   // sampling mode and detect flag
   //==========================================================
   logic meas_on;
   logic meas_done;

   srmc_sampler u_samp (
      .clk       (clk),
      .rstn      (rstn),
      .run       (sm_sampling),
      .rc_tick   (rc_tick),
      .rate      (sampling_rate_select),
      .meas_on   (meas_on),
      .meas_done (meas_done)
   );

   // sampling also keeps the rc oscillator requested
   always_ff @(posedge clk) begin
      if (!rstn) begin
         sm_sampling    <= 1'b0;
         rc_osc_request <= 1'b0;
         sm_measure_en  <= 1'b0;
      end else begin
         sm_sampling    <= monitor_on_indicator &&
                           (deep_sleep_mode || static_sleep_mode ||
                            force_sampling);
         rc_osc_request <= monitor_on_indicator &&
                           (deep_sleep_mode || static_sleep_mode ||
                            force_sampling);
         sm_measure_en  <= monitor_on_indicator &&
                           (!sm_sampling || meas_on);
      end
   end

   // in sampling mode the flag updates only at measurement ends
   always_ff @(posedge clk) begin
      if (!rstn) begin
         supply_detect_flag <= 1'b0;
      end else if (!monitor_on_indicator) begin
         supply_detect_flag <= 1'b0;
      end else if (!sm_sampling || meas_done) begin
         supply_detect_flag <= sm_below_in;
      end
   end

   //==========================================================
   // interrupt and reset request
   //==========================================================
   logic flag_prev_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         flag_prev_q <= 1'b0;
         irq         <= 1'b0;
      end else begin
         flag_prev_q <= supply_detect_flag;
         irq <= supply_detect_flag && !flag_prev_q
                && interrupt_mask;
      end
   end

   // masked detectors and flag-only mode never raise reset
   // raw inputs: the value flops read zero just after reset
   always_ff @(posedge clk) begin
      if (!rstn) begin
         por_request <= 1'b0;
      end else begin
         por_request <=
            (high_supply_detector_state && !req_s[S_HS_MASK]
             && !hs_det_in) ||
            (core_detector_state && !req_s[S_CORE_MSK]
             && !core_det_in) ||
            ((sm_ctrl == CTRL_RESET) && supply_detect_flag);
      end
   end

   //==========================================================
   // assertions
   //==========================================================
   property p_lock;
      @(posedge clk) disable iff (!rstn)
      vreg_wr && !unlock && !wake_shutdown |=> $stable(reg_en);
   endproperty
   a_lock: assert property (p_lock)
      else $error("locked write changed regulator enable");

   property p_freeze;
      @(posedge clk) disable iff (!rstn)
      vreg_frozen && cpu_run_ok |=> vreg_frozen && $stable(trim_value);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("frozen regulator register changed");

   property p_reg_on;
      @(posedge clk) disable iff (!rstn)
      $rose(reg_en) ##1 reg_en |-> ##1 reg_on;
   endproperty
   a_reg_on: assert property (p_reg_on)
      else $error("regulator on bit not after two cycles");

   property p_value;
      @(posedge clk) disable iff (!rstn)
      ##1 1'b1 |-> high_supply_detector_output == $past(hs_det_in);
   endproperty
   a_value: assert property (p_value)
      else $error("high supply value bit wrong");

   property p_debug;
      @(posedge clk) disable iff (!rstn)
      debug_active && core_en_q |=> core_en_q;
   endproperty
   a_debug: assert property (p_debug)
      else $error("core detector disabled during debug");

   property p_sm_hs;
      @(posedge clk) disable iff (!rstn)
      (sm_ctrl != CTRL_OFF) [*3] |-> !high_supply_detector_state;
   endproperty
   a_sm_hs: assert property (p_sm_hs)
      else $error("monitor on but high supply detector on");

   property p_por;
      @(posedge clk) disable iff (!rstn)
      sm_ctrl == CTRL_RESET && supply_detect_flag |=> por_request;
   endproperty
   a_por: assert property (p_por)
      else $error("low supply did not request reset");

   property p_irq;
      @(posedge clk) disable iff (!rstn)
      $rose(supply_detect_flag) && interrupt_mask |=> irq ##1 !irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not a single pulse on flag rise");

   property p_cal;
      @(posedge clk) disable iff (!rstn)
      cal_q == CAL_LOAD && fuse_valid |=>
         trim_value == $past(fuse_trim) && fuse_calibration_done
         && cpu_run_ok;
   endproperty
   a_cal: assert property (p_cal)
      else $error("fuse trim not loaded");
endmodule : srmc_ctrl

// >>> dv/tb.sv
//=============================================================
// tb
//=============================================================
// Purpose: self-checking bench for srmc_ctrl
// Assumes: inputs driven at falling edge, 50 MHz clock
// Notes:   status bits checked after sync latency; hs_mask also checked once within it
`timescale 1ns/1ps
module tb
   import srmc_pkg::*;
;
   logic clk = 1'b0, rstn = 1'b0, por_rst = 1'b1, wake_shutdown = 1'b0;
   logic debug_active = 1'b0, deep_sleep_mode = 1'b0;
   logic static_sleep_mode = 1'b0, rc_tick = 1'b0, fuse_valid = 1'b0;
   logic [7:0] fuse_trim = 8'h00, w_trim = 8'h00;
   logic unlock = 1'b1, vreg_wr = 1'b0, w_reg_en = 1'b1, w_fcd = 1'b0;
   logic [1:0] w_level = 2'h0, w_sm_ctrl = 2'h0;
   logic w_hs_en = 1'b1, w_hs_mask = 1'b0, w_core_en = 1'b1;
   logic w_core_mask = 1'b0, w_vreg_freeze = 1'b0, sm_wr = 1'b0;
   logic w_force_sampling = 1'b0, w_sm_freeze = 1'b0;
   logic [2:0] w_rate = 3'h0;
   logic int_enable_set = 1'b0, int_disable_set = 1'b0;
   logic reg_ok_in = 1'b0, hs_det_in = 1'b1, core_det_in = 1'b1;
   logic sm_below_in = 1'b0;
   logic reg_en, fcd, cpu_run_ok, vreg_frozen, reg_on, reg_ok, hs_state;
   logic hs_mask, hs_out, core_state, core_mask, core_out, force_smp;
   logic sm_frozen, mon_on, sm_sampling, meas_en, rc_req, flag, imask;
   logic irq, por_request;
   logic [1:0] level, sm_ctrl;
   logic [7:0] trim;
   logic [2:0] rate;
   int mismatches = 0;
   int checked = 0;
   logic [1:0] rc_div = 2'h0;
   logic rc_on = 1'b0;

   // free-running system clock
   always #10 clk = ~clk;

   // rc oscillator model: a tick every fourth clock while it runs
   always @(negedge clk) begin
      rc_div  = (rc_on || rc_req) ? rc_div + 2'h1 : 2'h0;
      rc_tick = (rc_on || rc_req) && (rc_div == 2'h1);
   end

   srmc_ctrl i_srmc_ctrl (.clk(clk), .rstn(rstn), .por_rst(por_rst),
      .wake_shutdown(wake_shutdown), .debug_active(debug_active),
      .deep_sleep_mode(deep_sleep_mode),
      .static_sleep_mode(static_sleep_mode), .rc_tick(rc_tick),
      .fuse_valid(fuse_valid), .fuse_trim(fuse_trim), .unlock(unlock),
      .vreg_wr(vreg_wr), .w_reg_en(w_reg_en), .w_level(w_level),
      .w_trim(w_trim), .w_fcd(w_fcd), .w_hs_en(w_hs_en),
      .w_hs_mask(w_hs_mask), .w_core_en(w_core_en),
      .w_core_mask(w_core_mask), .w_vreg_freeze(w_vreg_freeze),
      .sm_wr(sm_wr), .w_sm_ctrl(w_sm_ctrl),
      .w_force_sampling(w_force_sampling), .w_rate(w_rate),
      .w_sm_freeze(w_sm_freeze), .int_enable_set(int_enable_set),
      .int_disable_set(int_disable_set), .reg_ok_in(reg_ok_in),
      .hs_det_in(hs_det_in), .core_det_in(core_det_in),
      .sm_below_in(sm_below_in), .reg_en(reg_en),
      .output_level_select(level), .trim_value(trim),
      .fuse_calibration_done(fcd), .cpu_run_ok(cpu_run_ok),
      .vreg_frozen(vreg_frozen), .reg_on(reg_on),
      .regulator_output_ok(reg_ok),
      .high_supply_detector_state(hs_state),
      .high_supply_reset_mask(hs_mask),
      .high_supply_detector_output(hs_out),
      .core_detector_state(core_state), .core_reset_mask(core_mask),
      .core_detector_output(core_out), .sm_ctrl(sm_ctrl),
      .force_sampling(force_smp), .sampling_rate_select(rate),
      .sm_frozen(sm_frozen), .monitor_on_indicator(mon_on),
      .sm_sampling(sm_sampling), .sm_measure_en(meas_en),
      .rc_osc_request(rc_req), .supply_detect_flag(flag),
      .interrupt_mask(imask), .irq(irq), .por_request(por_request));

   // =============================================================
   // access tasks
   // =============================================================
   task chk(input logic [7:0] s, input logic [7:0] e);
      checked++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, s, e);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask : cyc

   // one regulator register write, strobe held one edge
   task wv(input logic en, input logic [7:0] tr, input logic fc,
           input logic he, input logic hm, input logic ce,
           input logic cm, input logic fz);
      vreg_wr = 1'b1; w_reg_en = en; w_trim = tr; w_fcd = fc;
      w_hs_en = he; w_hs_mask = hm; w_core_en = ce; w_core_mask = cm;
      w_vreg_freeze = fz;
      cyc(1);
      vreg_wr = 1'b0;
      cyc(1);
   endtask : wv

   task ws(input logic [1:0] c, input logic fs, input logic [2:0] r,
           input logic fz);
      sm_wr = 1'b1; w_sm_ctrl = c; w_force_sampling = fs; w_rate = r;
      w_sm_freeze = fz;
      cyc(1);
      sm_wr = 1'b0;
      cyc(1);
   endtask : ws

   // twelve-cycle reset; p chooses power-on or plain reset
   task rst(input logic p);
      rstn = 1'b0; por_rst = p;
      cyc(12);
      rstn = 1'b1; por_rst = 1'b0;
      cyc(1);
   endtask : rst

   task fuse(input logic [7:0] t);
      fuse_trim = t; fuse_valid = 1'b1;
      cyc(1);
      fuse_valid = 1'b0;
   endtask : fuse

   task wrap_up;
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up

   // watchdog: the whole sequence needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge clk);
      mismatches++;
      wrap_up();
   end

   // =============================================================
   // main sequence
   // =============================================================
   initial begin
      rst(1'b1);
      chk(reg_en, 1); chk(level, SEL_1V8);
      chk(cpu_run_ok, 0); chk(fcd, 0); chk(reg_ok, 0);
      chk(hs_state, 1); chk(core_state, 1); chk(mon_on, 0);
      fuse(8'h5a);
      chk(trim, 8'h5a); chk(fcd, 1); chk(cpu_run_ok, 1);
      reg_ok_in = 1'b1; cyc(2);
      chk(reg_ok, 1); chk(hs_out, 1); chk(core_out, 1);
      unlock = 1'b0; wv(0, 8'h11, 1, 1, 0, 1, 0, 0); unlock = 1'b1;
      chk(reg_en, 1); chk(trim, 8'h5a);
      wv(0, 8'h33, 0, 1, 1, 1, 1, 0);
      chk(reg_en, 0); chk(trim, 8'h33);
      chk(hs_mask, 0); cyc(4);
      chk(hs_mask, 1); chk(core_mask, 1);
      chk(reg_on, 0);
      rst(1'b0);
      chk(cpu_run_ok, 0); fuse(8'h6c); chk(cpu_run_ok, 1);
      chk(hs_mask, 1); chk(core_mask, 1);
      debug_active = 1'b1; rc_on = 1'b1;
      wv(1, 8'h6c, 1, 0, 1, 0, 1, 0); cyc(4);
      chk(core_state, 1); chk(hs_state, 0); debug_active = 1'b0;
      rc_on = 1'b0;
      wv(0, 8'h6c, 1, 1, 1, 1, 1, 0);
      wake_shutdown = 1'b1; cyc(1); wake_shutdown = 1'b0;
      chk(reg_en, 1);
      wv(1, 8'h6c, 1, 1, 1, 1, 1, 1); chk(vreg_frozen, 1);
      wv(0, 8'h21, 1, 1, 1, 1, 1, 0); chk(reg_en, 1);
      rst(1'b0);
      chk(vreg_frozen, 1); chk(cpu_run_ok, 1);
      rst(1'b1); fuse(8'h5a);
      chk(vreg_frozen, 0); chk(reg_en, 1);
      core_det_in = 1'b0; cyc(2);
      chk(core_out, 0); chk(por_request, 1); core_det_in = 1'b1;
      unlock = 1'b0; ws(2, 0, 0, 0); unlock = 1'b1;
      chk(sm_ctrl, 0);
      ws(CTRL_FLAG, 0, 0, 0); cyc(3);
      chk(mon_on, 1); chk(hs_state, 0);
      int_enable_set = 1'b1; cyc(1); int_enable_set = 1'b0;
      chk(imask, 1);
      sm_below_in = 1'b1; cyc(1); chk(flag, 1); chk(irq, 0);
      cyc(1); chk(irq, 1); chk(por_request, 0);
      cyc(1); chk(irq, 0);
      sm_below_in = 1'b0; cyc(2); chk(flag, 0);
      ws(CTRL_RESET, 0, 0, 0);
      sm_below_in = 1'b1; cyc(2); chk(por_request, 1);
      sm_below_in = 1'b0;
      ws(CTRL_RESET, 1, 3'h3, 0); cyc(2);
      chk(sm_sampling, 1); chk(rc_req, 1);
      chk(force_smp, 1); sm_below_in = 1'b1; cyc(2);
      chk(flag, 0); chk(meas_en, 1); cyc(2);
      chk(flag, 1); cyc(3); chk(meas_en, 0); chk(por_request, 1);
      sm_below_in = 1'b0;
      ws(CTRL_RESET, 0, 3'h3, 1); cyc(2);
      chk(sm_frozen, 1); chk(rate, 3'h3); chk(sm_sampling, 0);
      ws(CTRL_FLAG, 1, 0, 0); chk(sm_ctrl, CTRL_RESET);
      deep_sleep_mode = 1'b1; cyc(2);
      chk(sm_sampling, 1); chk(rc_req, 1);
      deep_sleep_mode = 1'b0; static_sleep_mode = 1'b1; cyc(2);
      chk(sm_sampling, 1);
      wrap_up();
   end
endmodule : tb
